//--- hdl/crf_core_regs.sv
// programmer-visible register set of the core with x/y address units
// ******************************************************************
// ******************************************************************
//
// Decided for this implementation: the register offsets and the plain strobed port.
module crf_core_regs
(
  input wire logic clock,                  // core clock, 200 MHz
  input wire logic rst,                    // synchronous reset
  input wire logic [7:0] bus_addr,         // register byte address
  input wire logic [7:0] bus_wdata,        // register write byte
  input wire logic bus_wr,                 // register write strobe
  input wire logic bus_rd,                 // register read strobe
  output logic [7:0] bus_rdata,            // read byte, next cycle
  input wire logic ex_wr,                  // working register write
  input wire logic [3:0] ex_wr_idx,        // target register
  input wire logic [15:0] ex_wr_data,      // write value
  input wire logic ex_wr_byte,             // byte-sized operation
  input wire logic [3:0] ex_rd_idx,        // operand register select
  output logic [15:0] ex_rd_data,          // operand, next cycle
  input wire logic acc_wr,                 // accumulator write
  input wire logic acc_sel,                // 0 selects a, 1 selects b
  input wire logic [39:0] acc_data,        // accumulator value
  input wire logic sr_wr,                  // status update from alu
  input wire logic [15:0] sr_data,         // new status word
  input wire logic shadow_push,            // fast context save
  input wire logic shadow_pop,             // fast context restore
  input wire logic loop_start,             // hardware loop begins
  input wire logic [15:0] loop_start_in,   // new loop_start_addr
  input wire logic [15:0] loop_end_in,     // new loop_end_addr
  input wire logic [15:0] loop_count_in,   // new loop_counter
  input wire logic loop_done,              // hardware loop completes
  input wire logic call_push,              // subroutine call
  input wire logic ret_pop,                // subroutine return
  input wire logic exc_entry,              // exception entry
  input wire logic frame_link_op,          // frame link
  input wire logic frame_unlink_op,        // frame unlink
  input wire logic [15:0] frame_size,      // frame size in bytes
  input wire logic [15:0] unlink_data,     // frame pointer popped
  input wire logic pc_load,                // program counter jump
  input wire logic [22:0] pc_target,       // jump target
  input wire logic pc_step,                // advance one instruction
  input wire logic mac_req,                // mac-class data read
  input wire logic mac_x_sel,              // x from reg 9, else 8
  input wire logic mac_y_sel,              // y from reg 11, else 10
  output logic stk_wr,                     // stack write pulse
  output logic stk_two,                    // two words in stk_wdata
  output logic [15:0] stk_addr,            // stack write address
  output logic [31:0] stk_wdata,           // high word, low word
  output logic [15:0] sp_out,              // stack pointer
  output logic [15:0] status_word,         // status register
  output logic [22:0] pc_out,              // program counter
  output logic [15:0] x_ea,                // x effective address
  output logic [15:0] y_ea,                // y effective address
  output logic mac_valid,                  // both addresses valid
  output logic x_err,                      // x address in y block
  output logic y_err                       // y address outside y
);
  import crf_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [NUM_W-1:0][WORD_W-1:0] w;    // working registers
    logic [NUM_SH-1:0][WORD_W-1:0] sh_w; // shadows of working regs 0 to 3
    logic [ACC_W-1:0] acc_a;            // accumulator_a
    logic [ACC_W-1:0] acc_b;            // accumulator_b
    logic [15:0] sr;                    // status_word
    logic [15:0] sh_sr;                 // shadowed flags
    logic [PC_W-1:0] pc;                // program counter
    logic [3:0][15:0] lp;               // start, end, count, repeat
    logic [2:0][15:0] sh_lp;            // shadows of start, end, count
    logic [7:0] tbl_pg;                 // table_page_reg
    logic [7:0] psv_pg;                 // program_visibility_page_reg
    logic [1:0] depth;                  // loop nesting
    logic [7:0] rd_byte;                // bus read answer
    logic [15:0] rd_word;               // operand answer
    logic stk_wr;                       // stack write pulse
    logic stk_two;                      // two stacked words
    logic [15:0] stk_addr;              // stack address
    logic [31:0] stk_data;              // stacked words
  } crf_state_type;

  crf_state_type s_q;  // registered state
  crf_state_type s_d;  // next state

  // ****************************************************************
  // byte map decode
  // ****************************************************************
  // region of a byte address
  function automatic crf_region_type region_of(input logic [7:0] a);
    if (a < OFS_ACC_A)
      region_of = RG_WREG;
    else if (a >= OFS_ACC_A && a < OFS_ACC_A + 8'h05)
      region_of = RG_ACC_A;
    else if (a >= OFS_ACC_B && a < OFS_ACC_B + 8'h05)
      region_of = RG_ACC_B;
    else if (a >= OFS_PC && a < OFS_PC + 8'h03)
      region_of = RG_PC;
    else if (a >= OFS_LOOP && a < OFS_TBL_PG)
      region_of = RG_LOOP;
    else if (a == OFS_TBL_PG || a == OFS_PSV_PG)
      region_of = RG_PAGE;
    else if (a == OFS_STAT || a == OFS_TOP)
      region_of = RG_STAT;
    else
      region_of = RG_NONE;
  endfunction

  // byte lane n of a wide field
  function automatic logic [7:0] lane(input logic [63:0] v,
                                      input logic [2:0] n);
    lane = v[{n, 3'b000} +: 8];
  endfunction

  // wide field with byte lane n replaced
  function automatic logic [63:0] put_lane(input logic [63:0] v,
                                           input logic [2:0] n,
                                           input logic [7:0] b);
    put_lane = v;
    put_lane[{n, 3'b000} +: 8] = b;
  endfunction

  // index of a loop word from its byte address
  function automatic logic [1:0] loop_idx(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - OFS_LOOP;
    loop_idx = rel[2:1];
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    s_d = s_q;
    s_d.stk_wr = 1'b0;
    s_d.stk_two = 1'b0;
    if (rst)
    begin
      s_d = '0;
      s_d.sr = ST_RESET;
      s_d.w[IDX_SP] = SP_RESET;
    end
    else
    begin
      if (bus_wr)
      begin
        case (region_of(bus_addr))
          RG_WREG:
            s_d.w[bus_addr[4:1]][{bus_addr[0], 3'b000} +: 8] = bus_wdata;
          RG_ACC_A:
            s_d.acc_a = ACC_W'(put_lane(64'(s_q.acc_a), bus_addr[2:0],
                                        bus_wdata));
          RG_ACC_B:
            s_d.acc_b = ACC_W'(put_lane(64'(s_q.acc_b), bus_addr[2:0],
                                        bus_wdata));
          RG_PC:
            s_d.pc = PC_W'(put_lane(64'(s_q.pc), {1'b0, bus_addr[1:0]},
                                    bus_wdata));
          RG_LOOP:
            s_d.lp[loop_idx(bus_addr)][{bus_addr[0], 3'b000} +: 8] =
              bus_wdata;
          RG_PAGE:
            if (bus_addr[0])
              s_d.psv_pg = bus_wdata;
            else
              s_d.tbl_pg = bus_wdata;
          RG_STAT:
            s_d.sr[{bus_addr[0], 3'b000} +: 8] = bus_wdata;
          default:
            s_d.tbl_pg = s_d.tbl_pg;  // unmapped: ignored
        endcase
      end
      if (ex_wr)
      begin
        if (ex_wr_byte)
          s_d.w[ex_wr_idx][7:0] = ex_wr_data[7:0];
        else
          s_d.w[ex_wr_idx] = ex_wr_data;
      end
      // accumulator write
      if (acc_wr)
      begin
        if (acc_sel)
          s_d.acc_b = acc_data;
        else
          s_d.acc_a = acc_data;
      end
      if (sr_wr)
      begin
        s_d.sr = sr_data;
        s_d.sr[ST_LOOP] = s_q.sr[ST_LOOP];
      end
      if (shadow_push)
      begin
        s_d.sh_w = s_q.w[NUM_SH-1:0];
        s_d.sh_sr = s_q.sr & ST_SHADOW_MASK;
      end
      else if (shadow_pop)
      begin
        s_d.w[NUM_SH-1:0] = s_q.sh_w;
        s_d.sr = (s_d.sr & ~ST_SHADOW_MASK) | s_q.sh_sr;
      end
      if (loop_start)
      begin
        s_d.sh_lp = s_q.lp[2:0];
        s_d.lp[0] = loop_start_in;
        s_d.lp[1] = loop_end_in;
        s_d.lp[2] = loop_count_in;
        s_d.sr[ST_LOOP] = 1'b1;
        if (s_q.depth != 2'b11)
          s_d.depth = s_q.depth + 2'b01;
      end
      else if (loop_done)
      begin
        s_d.lp[2:0] = s_q.sh_lp;
        if (s_q.depth != 2'b00)
          s_d.depth = s_q.depth - 2'b01;
        s_d.sr[ST_LOOP] = (s_q.depth > 2'b01);
      end
      // exception stacks pc low, then status low and pc msb
      if (exc_entry)
      begin
        s_d.stk_wr = 1'b1;
        s_d.stk_two = 1'b1;
        s_d.stk_addr = s_q.w[IDX_SP];
        s_d.stk_data = {s_q.sr[7:0], 1'b0, s_q.pc[22:16], s_q.pc[15:0]};
        s_d.w[IDX_SP] = s_q.w[IDX_SP] + STK_PAIR;
      end
      else if (call_push)
      begin
        s_d.stk_wr = 1'b1;
        s_d.stk_two = 1'b1;
        s_d.stk_addr = s_q.w[IDX_SP];
        s_d.stk_data = {9'h000, s_q.pc[22:16], s_q.pc[15:0]};
        s_d.w[IDX_SP] = s_q.w[IDX_SP] + STK_PAIR;
      end
      else if (ret_pop)
        s_d.w[IDX_SP] = s_q.w[IDX_SP] - STK_PAIR;
      else if (frame_link_op)
      begin
        s_d.stk_wr = 1'b1;
        s_d.stk_addr = s_q.w[IDX_SP];
        s_d.stk_data = {16'h0000, s_q.w[IDX_FP]};
        s_d.w[IDX_FP] = s_q.w[IDX_SP] + STK_WORD;
        s_d.w[IDX_SP] = s_q.w[IDX_SP] + STK_WORD + frame_size;
      end
      else if (frame_unlink_op)
      begin
        s_d.w[IDX_SP] = s_q.w[IDX_FP] - STK_WORD;
        s_d.w[IDX_FP] = unlink_data;
      end
      // program counter
      if (pc_load)
        s_d.pc = pc_target;
      else if (pc_step)
        s_d.pc = s_q.pc + PC_W'(2);
      s_d.pc[0] = 1'b0;
      s_d.w[IDX_SP][0] = 1'b0;
    end
    // register read answers
    if (!rst && bus_rd)
    begin
      case (region_of(bus_addr))
        RG_WREG:
          s_d.rd_byte = s_q.w[bus_addr[4:1]][{bus_addr[0], 3'b000} +: 8];
        RG_ACC_A:
          s_d.rd_byte = lane(64'(s_q.acc_a), bus_addr[2:0]);
        RG_ACC_B:
          s_d.rd_byte = lane(64'(s_q.acc_b), bus_addr[2:0]);
        RG_PC:
          s_d.rd_byte = lane(64'(s_q.pc), {1'b0, bus_addr[1:0]});
        RG_LOOP:
          s_d.rd_byte =
            s_q.lp[loop_idx(bus_addr)][{bus_addr[0], 3'b000} +: 8];
        RG_PAGE:
          s_d.rd_byte = bus_addr[0] ? s_q.psv_pg : s_q.tbl_pg;
        RG_STAT:
          s_d.rd_byte = s_q.sr[{bus_addr[0], 3'b000} +: 8];
        default:
          s_d.rd_byte = 8'h00;
      endcase
    end
    // operand read port
    if (!rst)
      s_d.rd_word = s_q.w[ex_rd_idx];
  end

  // state register
  always_ff @(posedge clock)
  begin
    s_q <= s_d;
  end

  // ****************************************************************
  // mac address generators
  // ****************************************************************
  logic x_valid;  // x unit answer valid
  logic y_valid;  // y unit answer valid

  crf_agu #(.LO(Y_BASE), .HI(Y_TOP), .IS_Y(1'b0)) u_agu_x
  (
    .clock(clock),
    .rst(rst),
    .req(mac_req),
    .ea(mac_x_sel ? s_q.w[IDX_X_B] : s_q.w[IDX_X_A]),
    .ea_out(x_ea),
    .valid(x_valid),
    .region_err(x_err)
  );

  crf_agu #(.LO(Y_BASE), .HI(Y_TOP), .IS_Y(1'b1)) u_agu_y
  (
    .clock(clock),
    .rst(rst),
    .req(mac_req),
    .ea(mac_y_sel ? s_q.w[IDX_Y_B] : s_q.w[IDX_Y_A]),
    .ea_out(y_ea),
    .valid(y_valid),
    .region_err(y_err)
  );

  // outputs straight from flip-flops
  assign mac_valid = x_valid;
  assign bus_rdata = s_q.rd_byte;
  assign ex_rd_data = s_q.rd_word;
  assign stk_wr = s_q.stk_wr;
  assign stk_two = s_q.stk_two;
  assign stk_addr = s_q.stk_addr;
  assign stk_wdata = s_q.stk_data;
  assign sp_out = s_q.w[IDX_SP];
  assign status_word = s_q.sr;
  assign pc_out = s_q.pc;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // exception entry then its stacked words
  sequence exc_seq;
    exc_entry && !bus_wr;
  endsequence
  sequence exc_out;
    stk_wr && stk_two && stk_wdata[31:24] == $past(s_q.sr[7:0])
      && sp_out == $past(sp_out) + STK_PAIR;
  endsequence

  chk_sp_reset: assert property (disable iff (1'b0)
    rst |=> sp_out == SP_RESET)
    else $error("stack pointer reset value wrong");
  chk_sp_even: assert property (sp_out[0] == 1'b0)
    else $error("stack pointer odd");
  chk_pc_even: assert property (pc_out[0] == 1'b0)
    else $error("program counter odd");
  chk_exc_stack: assert property (exc_seq |=> exc_out)
    else $error("exception stacking wrong");
  chk_byte_upper: assert property (
    ex_wr && ex_wr_byte && !bus_wr && !shadow_pop && ex_wr_idx < IDX_FP
      && ex_wr_idx >= 4'h4
    |=> s_q.w[$past(ex_wr_idx)][15:8] == $past(s_q.w[ex_wr_idx][15:8]))
    else $error("byte write touched upper byte");
  chk_shadow_pop: assert property (
    shadow_pop && !shadow_push && !ex_wr && !bus_wr && !sr_wr
    |=> s_q.w[0] == $past(s_q.sh_w[0])
      && (status_word & ST_SHADOW_MASK) == $past(s_q.sh_sr))
    else $error("shadow restore wrong");
  chk_loop_save: assert property (
    loop_start && !bus_wr
    |=> s_q.sh_lp[0] == $past(s_q.lp[0]) && s_q.lp[0] == $past(loop_start_in)
      && status_word[ST_LOOP])
    else $error("loop start save wrong");
  chk_loop_back: assert property (
    loop_done && !loop_start && !bus_wr
    |=> s_q.lp[2] == $past(s_q.sh_lp[2]))
    else $error("loop end restore wrong");
  chk_stat_read: assert property (
    bus_rd && bus_addr == OFS_TOP ##1 !bus_rd [*2]
    |-> bus_rdata == $past(status_word[15:8], 2))
    else $error("status high byte read wrong");
  chk_mac_pair: assert property (
    mac_req |=> mac_valid && y_valid)
    else $error("mac addresses not paired");

endmodule

//--- include/crf_pkg.sv
// shared constants and types of the core register file
package crf_pkg;

  // ****************************************************************
  // widths and counts
  // ****************************************************************
  localparam int unsigned WORD_W = 16;  // working register width
  localparam int unsigned ACC_W = 40;   // accumulator width
  localparam int unsigned PC_W = 23;    // program counter width
  localparam int unsigned NUM_W = 16;   // working register count
  localparam int unsigned NUM_SH = 4;   // working regs with a shadow
  localparam int unsigned ADDR_W = 8;   // byte address of the register window

  // ****************************************************************
  // working registers with fixed duties
  // ****************************************************************
  localparam logic [3:0] IDX_DEFAULT = 4'h0;  // default_work_reg
  localparam logic [3:0] IDX_X_A = 4'h8;      // x_addr_reg_a
  localparam logic [3:0] IDX_X_B = 4'h9;      // x_addr_reg_b
  localparam logic [3:0] IDX_Y_A = 4'ha;      // y_addr_reg_a
  localparam logic [3:0] IDX_Y_B = 4'hb;      // y_addr_reg_b
  localparam logic [3:0] IDX_FP = 4'he;       // frame_pointer_reg
  localparam logic [3:0] IDX_SP = 4'hf;       // stack_pointer_reg

  // ****************************************************************
  // byte map of the register window
  // ****************************************************************
  localparam logic [7:0] OFS_ACC_A = 8'h20;  // 5 bytes, low first
  localparam logic [7:0] OFS_ACC_B = 8'h28;  // 5 bytes, low first
  localparam logic [7:0] OFS_PC = 8'h30;     // 3 bytes, low first
  localparam logic [7:0] OFS_LOOP = 8'h34;   // start, end, count, rep
  localparam logic [7:0] OFS_TBL_PG = 8'h3c; // table_page_reg
  localparam logic [7:0] OFS_PSV_PG = 8'h3d; // program_visibility_page
  localparam logic [7:0] OFS_STAT = 8'h3e;   // status low, then high
  localparam logic [7:0] OFS_TOP = 8'h3f;    // last mapped byte

  // ****************************************************************
  // status word fields and reset values
  // ****************************************************************
  localparam int unsigned ST_CARRY = 0;    // carry
  localparam int unsigned ST_ZERO = 1;     // zero
  localparam int unsigned ST_OVERFLOW = 2; // overflow_flag
  localparam int unsigned ST_NEG = 3;      // negative
  localparam int unsigned ST_REPEAT = 4;   // repeat_active_flag
  localparam int unsigned ST_PRIO = 5;     // cpu_priority_level, 3 bits
  localparam int unsigned ST_DIGIT = 8;    // digit_carry_flag
  localparam int unsigned ST_LOOP = 9;     // loop_active_flag
  localparam logic [15:0] ST_SHADOW_MASK = 16'h010f;
  localparam logic [15:0] ST_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0800;
  localparam logic [15:0] STK_WORD = 16'h0002;  // one stacked word
  localparam logic [15:0] STK_PAIR = 16'h0004;  // two stacked words

  // ****************************************************************
  // default y block inside the x block
  // ****************************************************************
  localparam logic [7:0] Y_BASE = 8'h80;
  localparam logic [7:0] Y_TOP = 8'hbf;

  // regions of the register window
  typedef enum logic [2:0] {
    RG_NONE, RG_WREG, RG_ACC_A, RG_ACC_B, RG_PC, RG_LOOP, RG_PAGE, RG_STAT
  } crf_region_type;

endpackage

//--- hdl/crf_agu.sv
// one address generator of the split x/y data space
module crf_agu
#(
  parameter logic [7:0] LO = crf_pkg::Y_BASE,  // first byte of y block
  parameter logic [7:0] HI = crf_pkg::Y_TOP,   // last byte of y block
  parameter bit IS_Y = 1'b0                    // unit serves y space
)
(
  input wire logic clock,         // core clock
  input wire logic rst,           // synchronous reset
  input wire logic req,           // mac read request
  input wire logic [15:0] ea,     // effective address from a register
  output logic [15:0] ea_out,     // registered effective address
  output logic valid,             // address valid, one cycle
  output logic region_err         // x unit: address in the y block; y unit: address outside it
);
  import crf_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [15:0] ea;   // latched address
    logic valid;       // pulse beside the address
    logic err;         // space violation beside the address
  } crf_agu_type;

  crf_agu_type s_q;  // registered state
  crf_agu_type s_d;  // next state

  // byte address lies in the y block
  function automatic logic in_y(input logic [15:0] a);
    in_y = (a[15:8] == 8'h00) && (a[7:0] >= LO) && (a[7:0] <= HI);
  endfunction

  // next state: latch address and classify it
  always_comb
  begin
    s_d = s_q;
    s_d.valid = 1'b0;
    if (rst)
    begin
      s_d = '0;
    end
    else if (req)
    begin
      s_d.ea = ea;
      s_d.valid = 1'b1;
      s_d.err = IS_Y ? !in_y(ea) : in_y(ea);
    end
  end

  // state register
  always_ff @(posedge clock)
  begin
    s_q <= s_d;
  end

  assign ea_out = s_q.ea;
  assign valid = s_q.valid;
  assign region_err = s_q.err;

  chk_agu_region: assert property (@(posedge clock) disable iff (rst)
    req |=> valid && (region_err == (IS_Y ? !in_y(ea_out) : in_y(ea_out))))
    else $error("address space check wrong");

endmodule

//--- tb/crf_exec_model.sv
// behavioural execute stage issuing one-cycle core operations
module crf_exec_model
(
  input wire logic clock, // core clock
  output logic [15:0] s, // operation strobes, one bit each
  output logic [15:0] d // operand shared by every operation
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle until an operation is issued
  initial {s, d} = 32'h00000000;
  // hold an operation for exactly one sampling edge
  task automatic fire(input logic [15:0] o, input logic [15:0] v);
    @(posedge clock);
    s <= o;
    d <= v;
    @(posedge clock);
    // released operand flips so stale values are never trusted
    {s, d} <= {16'h0000, ~v};
    #1;
  endtask
endmodule

//--- tb/crf_core_regs_bench.sv
// self-checking bench of the core register file
module crf_core_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0; // core clock, 5 ns
  logic rst = 1'b1; // sync reset
  logic bw = 1'b0, br = 1'b0; // bus strobes
  logic [7:0] a = 8'h00, w = 8'h00; // bus address and byte
  logic [3:0] idx = 4'h0; // register and unit select
  logic [15:0] s, d; // model strobes and operand
  logic [7:0] bus_rdata; // read byte
  logic [15:0] ex_rd_data, stk_addr, sp_out, status_word, x_ea, y_ea;
  logic [31:0] stk_wdata; // stacked words
  logic [22:0] pc_out; // program counter
  logic stk_wr, stk_two, mac_valid, x_err, y_err; // pulses, flags
  int error_cnt = 0, comparisons = 0; // mismatches, compares
  // execute stage and register file
  crf_exec_model crf_exec_model_inst (.clock, .s, .d);
  crf_core_regs crf_core_regs_inst (.clock, .rst, .bus_addr(a),
    .bus_wdata(w), .bus_wr(bw), .bus_rd(br), .bus_rdata, .ex_wr(s[0]),
    .ex_wr_idx(idx), .ex_wr_data(d), .ex_wr_byte(s[15]),
    .ex_rd_idx(idx), .ex_rd_data, .acc_wr(s[1]), .acc_sel(idx[0]),
    .acc_data({d, d, d[7:0]}), .sr_wr(s[2]), .sr_data(d),
    .shadow_push(s[3]), .shadow_pop(s[4]), .loop_start(s[5]),
    .loop_start_in(d), .loop_end_in(d), .loop_count_in(d),
    .loop_done(s[6]), .call_push(s[7]), .ret_pop(s[8]),
    .exc_entry(s[9]), .frame_link_op(s[10]), .frame_unlink_op(s[11]),
    .frame_size(d), .unlink_data(d), .pc_load(s[12]),
    .pc_target({7'h00, d}), .pc_step(s[13]), .mac_req(s[14]),
    .mac_x_sel(idx[1]), .mac_y_sel(idx[2]), .stk_wr, .stk_two,
    .stk_addr, .stk_wdata, .sp_out, .status_word, .pc_out, .x_ea,
    .y_ea, .mac_valid, .x_err, .y_err);
  // compare and count
  task automatic chk(input logic [15:0] v, input logic [15:0] e);
    comparisons++;
    if (v !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t: saw %h, expected %h", $time, v, e);
    end
  endtask
  // one byte access; a read compares the byte of the next cycle
  task automatic bus(input logic r, input logic [7:0] ad,
                     input logic [7:0] v);
    @(posedge clock);
    a <= ad;
    w <= v;
    {br, bw} <= {r, !r};
    @(posedge clock);
    {br, bw} <= 2'b00;
    #1;
    if (r)
      chk(bus_rdata, v);
  endtask
  // one core operation through the execute model
  task automatic op(input logic [15:0] o, input logic [3:0] i,
                    input logic [15:0] v);
    @(posedge clock);
    idx <= i;
    crf_exec_model_inst.fire(o, v);
  endtask
  // verdict and end of run
  task automatic conclude();
    if (error_cnt == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // free-running clock
  initial forever #2.5 clock = ~clock;
  // hang guard
  initial
  begin
    #20000;
    error_cnt++;
    conclude();
  end
  // main sequence
  initial
  begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk(sp_out, 16'h0800);
    bus(1'b1, 8'h1f, 8'h08);
    bus(1'b0, 8'h1e, 8'h35);
    chk(sp_out, 16'h0834);
    op(16'h0001, 4'h5, 16'ha5c3);
    op(16'h8001, 4'h5, 16'h0011);
    bus(1'b1, 8'h0b, 8'ha5);
    bus(1'b0, 8'h0b, 8'h77);
    // operand port answers one cycle after the write lands
    @(posedge clock);
    #1;
    chk(ex_rd_data, 16'h7711);
    op(16'h0004, 4'h1, 16'hffff);
    chk(status_word, 16'hfdff);
    // second save overwrites the first, pop brings back the second
    op(16'h0008, 4'h1, 16'h0000);
    op(16'h0001, 4'h1, 16'h1234);
    op(16'h0008, 4'h1, 16'h0000);
    op(16'h0005, 4'h1, 16'h0000);
    op(16'h0010, 4'h1, 16'h0000);
    bus(1'b1, 8'h03, 8'h12);
    chk(status_word, 16'h010f);
    op(16'h1000, 4'h0, 16'h0035);
    op(16'h2000, 4'h0, 16'h0000);
    chk(pc_out[15:0], 16'h0036);
    op(16'h0200, 4'h0, 16'h0000);
    chk(stk_wdata[31:16], 16'h0f00);
    chk({stk_wr, stk_two}, 16'h0003);
    chk(stk_addr, 16'h0834);
    op(16'h0080, 4'h0, 16'h0000);
    chk(sp_out, 16'h083c);
    op(16'h0400, 4'h0, 16'h0004);
    chk(sp_out, 16'h0842);
    bus(1'b1, 8'h1c, 8'h3e);
    op(16'h0800, 4'h0, 16'h0000);
    chk(sp_out, 16'h083c);
    op(16'h0100, 4'h0, 16'h0000);
    chk(sp_out, 16'h0838);
    // nested loop start, then one completion
    op(16'h0020, 4'h0, 16'h0010);
    op(16'h0020, 4'h0, 16'h0020);
    op(16'h0040, 4'h0, 16'h0000);
    bus(1'b1, 8'h38, 8'h10);
    chk(status_word, 16'h030f);
    bus(1'b1, 8'h3f, 8'h03);
    op(16'h0001, 4'h8, 16'h0040);
    op(16'h0001, 4'hb, 16'h00c0);
    op(16'h4000, 4'h4, 16'h0000);
    chk({mac_valid, x_err, y_err}, 16'h0005);
    chk(y_ea, 16'h00c0);
    chk(x_ea, 16'h0040);
    op(16'h0002, 4'h1, 16'hbeef);
    bus(1'b1, 8'h2c, 8'hbe);
    bus(1'b1, 8'h40, 8'h00);
    // reset again in mid-run for one cycle
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    #1;
    chk(sp_out, 16'h0800);
    chk(status_word, 16'h0000);
    conclude();
  end
endmodule
